// ---- pkg/closed_loop_rate_cfg.svh ----
// register offsets, field positions, reset values and frequency scaling for the closed-loop config
`ifndef CLOSED_LOOP_RATE_CFG_SVH
`define CLOSED_LOOP_RATE_CFG_SVH

`define CLR_CONFIG_ONE_OFFSET 8'h88
`define CLR_STATUS_OFFSET 8'h8c
`define CLR_RESET_VALUE 32'h0000_0000
`define CLR_WRITE_MASK 32'h3fff_bfff
`define CLR_ACC_LSB 25
`define CLR_DEC_SRC_BIT 24
`define CLR_DEC_LSB 19
`define CLR_FREQ_LSB 15
`define CLR_PULSE_SEL_LSB 12
`define CLR_SURGE_BIT 3
`define CLR_NO_LIMIT 5'h1f
`define CLR_FREQ_MAX_CODE 4'hd
`define CLR_FREQ_BASE_KHZ 7'h0a
`define CLR_FREQ_STEP_KHZ 7'h05

`endif

// ---- pkg/closed_loop_rate_pkg.sv ----
// types shared by the closed-loop rate configuration block
package closed_loop_rate_pkg;

    typedef enum logic [1:0] {
        MODE_SPEED = 2'b00,
        MODE_POWER = 2'b01,
        MODE_CURRENT = 2'b10,
        MODE_VOLTAGE = 2'b11
    } ctrl_mode_e;

    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_DETECT = 2'b01,
        PHASE_OPEN = 2'b10,
        PHASE_CLOSED = 2'b11
    } motor_phase_e;

    typedef enum logic [1:0] {
        PULSE_ALL = 2'b00,
        PULSE_CLOSED_ONLY = 2'b01,
        PULSE_FIRST_TRY = 2'b10,
        PULSE_UNDEFINED = 2'b11
    } pulse_sel_e;

    // scaled rate: value in tenths of a unit per second, unit set by the control mode
    typedef struct packed {
        logic [19:0] tenths;
        logic noLimit;
        ctrl_mode_e unit;
    } rate_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage : closed_loop_rate_pkg

// ---- rtl/closed_loop_rate_config.sv ----
// closed-loop rate configuration register and its decoded controls
//
// Overview of operation
// R1 - bits 29:25 hold acceleration code; 0h-1Eh rate steps, 1Fh means unlimited
// R2 - rate units follow control mode: Hz, W, A or 0.1% index per second
// R3 - bit 24 clear uses deceleration code, set reuses acceleration code
// R4 - bits 23:19 hold deceleration code, same steps, 1Fh means unlimited
// R5 - deceleration code ignored when surge guard on in speed mode or bit 24 set
// R6 - bits 18:15 set switching frequency, 10 kHz plus 5 kHz per code to 75
// R7 - software must not write frequency codes Eh or Fh
// R8 - selection 0 passes speed pulses in detection, open and closed loop
// R9 - selection 1 passes speed pulses only in closed loop
// R10 - selection 2 passes pulses in open loop on first try only; 3 undefined
// R11 - bit 3 enables anti voltage surge, which also gates the deceleration code in speed mode
// R12 - register sits at 88h and clears to zero on reset
// R13 - bits 31, 30 and 14 read zero and ignore writes
//
// Chosen here: the address-and-strobe port and the register addresses.
`include "closed_loop_rate_cfg.svh"
`timescale 1ns/100ps
module closed_loop_rate_config
    import closed_loop_rate_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire reg_req_s regReq,
    output logic [31:0] rdata,
    // motor state
    input wire ctrl_mode_e ctrlMode,
    input wire motor_phase_e motorPhase,
    input wire logic firstTry,
    input wire logic rawSpeedPulse,
    // decoded controls
    output rate_s accelRate,
    output rate_s decelRate,
    output logic [6:0] switchFreqKhz,
    output logic freqCodeBad,
    output logic antiVoltageSurge,
    output logic speedPulseOutput
);

    typedef struct packed {
        logic [31:0] config1;
        logic [31:0] rdata;
        rate_s accel;
        rate_s decel;
        logic [6:0] freqKhz;
        logic freqBad;
        logic surge;
        logic pulse;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    rate_s accelDec;
    rate_s decelDec;

    // field extraction, applied only to the stored value
    function automatic logic [4:0] acc_code(input logic [31:0] r);
        acc_code = r[`CLR_ACC_LSB +: 5];
    endfunction : acc_code

    function automatic logic [4:0] dec_code(input logic [31:0] r);
        dec_code = r[`CLR_DEC_LSB +: 5];
    endfunction : dec_code

    // ==========================================================
    // rate lookups
    rate_code_decode accelLookup (
        .code(acc_code(st_r.config1)),
        .mode(ctrlMode),
        .rate(accelDec)
    );

    rate_code_decode decelLookup (
        .code(dec_code(st_r.config1)),
        .mode(ctrlMode),
        .rate(decelDec)
    );

    // ==========================================================
    // next state
    logic decSrc;
    logic surgeOn;
    logic [3:0] freqCode;
    pulse_sel_e pulseSel;

    always_comb begin
        st_nxt = st_r;
        decSrc = st_r.config1[`CLR_DEC_SRC_BIT];
        surgeOn = st_r.config1[`CLR_SURGE_BIT]; // see R11
        freqCode = st_r.config1[`CLR_FREQ_LSB +: 4];
        pulseSel = pulse_sel_e'(st_r.config1[`CLR_PULSE_SEL_LSB +: 2]);

        // register writes; reserved bits are masked out
        if (regReq.wr && regReq.addr == `CLR_CONFIG_ONE_OFFSET) begin
            st_nxt.config1 = regReq.wdata & `CLR_WRITE_MASK; // see R12, R13
        end

        st_nxt.rdata = 32'h0000_0000;
        if (regReq.rd && regReq.addr == `CLR_CONFIG_ONE_OFFSET) begin
            st_nxt.rdata = st_r.config1 & `CLR_WRITE_MASK; // see R13
        end else if (regReq.rd && regReq.addr == `CLR_STATUS_OFFSET) begin
            st_nxt.rdata = {24'h000000, st_r.freqBad, st_r.pulse, ctrlMode,
                            motorPhase, 2'h0};
        end

        st_nxt.accel = accelDec; // see R1, R2
        // surge guard only overrides in speed mode, which keeps power modes on their own code
        if (decSrc || (surgeOn && ctrlMode == MODE_SPEED)) begin
            st_nxt.decel = accelDec; // see R3, R5
        end else begin
            st_nxt.decel = decelDec; // see R4
        end

        // codes above Dh are clamped, flagged, and never produce a made-up frequency
        st_nxt.freqBad = (freqCode > `CLR_FREQ_MAX_CODE); // see R7
        if (st_nxt.freqBad) begin
            st_nxt.freqKhz = `CLR_FREQ_BASE_KHZ + 7'(`CLR_FREQ_MAX_CODE) * `CLR_FREQ_STEP_KHZ;
        end else begin
            st_nxt.freqKhz = `CLR_FREQ_BASE_KHZ + 7'(freqCode) * `CLR_FREQ_STEP_KHZ; // see R6
        end

        st_nxt.surge = surgeOn; // see R11

        case (pulseSel)
            PULSE_ALL: begin
                st_nxt.pulse = rawSpeedPulse && motorPhase != PHASE_IDLE; // see R8
            end
            PULSE_CLOSED_ONLY: begin
                st_nxt.pulse = rawSpeedPulse && motorPhase == PHASE_CLOSED; // see R9
            end
            PULSE_FIRST_TRY: begin
                st_nxt.pulse = rawSpeedPulse && motorPhase == PHASE_OPEN && firstTry; // see R10
            end
            default: begin
                st_nxt.pulse = 1'b0; // see R10
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0; // see R12
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign accelRate = st_r.accel;
    assign decelRate = st_r.decel;
    assign switchFreqKhz = st_r.freqKhz;
    assign freqCodeBad = st_r.freqBad;
    assign antiVoltageSurge = st_r.surge;
    assign speedPulseOutput = st_r.pulse;

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_cfgWrite;
        regReq.wr && regReq.addr == `CLR_CONFIG_ONE_OFFSET;
    endsequence

    a_reserved_reads_zero: assert property ( // see R13
        $past(regReq.rd) |-> (rdata[31:30] == 2'b00 && rdata[14] == 1'b0))
        else $error("reserved bits read nonzero");

    a_write_then_read: assert property ( // see R12
        s_cfgWrite ##1 (regReq.rd && regReq.addr == `CLR_CONFIG_ONE_OFFSET && !regReq.wr)
        |=> rdata == ($past(regReq.wdata, 2) & `CLR_WRITE_MASK))
        else $error("readback differs from write");

    a_accel_no_limit: assert property ( // see R1
        acc_code(st_r.config1) == `CLR_NO_LIMIT |=> accelRate.noLimit)
        else $error("code 1f did not remove limit");

    a_accel_unit: assert property ( // see R2
        ##1 accelRate.unit == $past(ctrlMode))
        else $error("rate unit not following mode");

    a_decel_source: assert property ( // see R3
        st_r.config1[`CLR_DEC_SRC_BIT] |=> decelRate == accelRate)
        else $error("decel not reusing accel code");

    a_decel_own_code: assert property ( // see R4
        (!st_r.config1[`CLR_DEC_SRC_BIT] && !st_r.config1[`CLR_SURGE_BIT])
        |=> decelRate.noLimit == ($past(dec_code(st_r.config1)) == `CLR_NO_LIMIT))
        else $error("decel code not applied");

    a_surge_speed: assert property ( // see R5
        (st_r.config1[`CLR_SURGE_BIT] && ctrlMode == MODE_SPEED) |=> decelRate == accelRate)
        else $error("decel code used under surge guard");

    a_freq_step: assert property ( // see R6
        (st_r.config1[`CLR_FREQ_LSB +: 4] == 4'hd) |=> switchFreqKhz == 7'h4b)
        else $error("code d not 75 khz");

    a_pulse_closed: assert property ( // see R9
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h1 && motorPhase != PHASE_CLOSED)
        |=> !speedPulseOutput)
        else $error("pulse outside closed loop");

    a_pulse_all: assert property ( // see R8
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h0 && motorPhase == PHASE_DETECT
         && rawSpeedPulse) |=> speedPulseOutput)
        else $error("pulse missing in detection");

    a_pulse_first: assert property ( // see R10
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h2 && !firstTry) |=> !speedPulseOutput)
        else $error("pulse after first try");

    a_surge_out: assert property ( // see R11
        ##1 antiVoltageSurge == $past(st_r.config1[`CLR_SURGE_BIT]))
        else $error("surge enable not reflected");

    // ==========================================================
    // register access and rule end points
    sequence s_cfgRead;
        regReq.rd && regReq.addr == `CLR_CONFIG_ONE_OFFSET;
    endsequence

    sequence s_otherWrite;
        regReq.wr && regReq.addr != `CLR_CONFIG_ONE_OFFSET;
    endsequence

    sequence s_otherRead;
        regReq.rd && regReq.addr != `CLR_CONFIG_ONE_OFFSET
            && regReq.addr != `CLR_STATUS_OFFSET;
    endsequence

    // write with the surge bit set: register takes it, output follows one edge later
    sequence s_surgeOnWrite;
        s_cfgWrite ##0 regReq.wdata[`CLR_SURGE_BIT];
    endsequence

    // reset itself is the subject here, so the default disable must not mask it
    a_reset_clears: assert property ( // see R12
        @(posedge core_clk) disable iff (1'b0)
        srst |=> (st_r.config1 == `CLR_RESET_VALUE && rdata == 32'h0000_0000))
        else $error("reset did not clear register");

    a_write_lands: assert property ( // see R12
        s_cfgWrite |=> st_r.config1 == ($past(regReq.wdata) & `CLR_WRITE_MASK))
        else $error("write did not land");

    a_reserved_dropped: assert property ( // see R13
        s_cfgWrite |=> (st_r.config1[31:30] == 2'b00 && st_r.config1[14] == 1'b0))
        else $error("reserved bits stored");

    a_other_write: assert property ( // see R12
        s_otherWrite |=> st_r.config1 == $past(st_r.config1))
        else $error("write to other offset landed");

    a_read_config: assert property ( // see R12
        s_cfgRead |=> rdata == ($past(st_r.config1) & `CLR_WRITE_MASK))
        else $error("config readback wrong");

    a_other_read: assert property ( // see R12
        s_otherRead |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_idle_rdata: assert property ( // see R12
        !regReq.rd |=> rdata == 32'h0000_0000)
        else $error("read data outlived its cycle");

    a_surge_after_write: assert property ( // see R11
        s_surgeOnWrite |=> ##1 antiVoltageSurge)
        else $error("surge enable late after write");

    a_accel_lowest: assert property ( // see R1
        acc_code(st_r.config1) == 5'h00
        |=> (accelRate.tenths == 20'h00005 && !accelRate.noLimit))
        else $error("code 0 not half a unit per second");

    a_accel_highest: assert property ( // see R1
        acc_code(st_r.config1) == 5'h1e
        |=> (accelRate.tenths == 20'haae60 && !accelRate.noLimit))
        else $error("code 1e not top rate");

    a_decel_lowest: assert property ( // see R4
        (!st_r.config1[`CLR_DEC_SRC_BIT] && !st_r.config1[`CLR_SURGE_BIT]
         && dec_code(st_r.config1) == 5'h00) |=> decelRate.tenths == 20'h00005)
        else $error("decel code 0 not half a unit per second");

    a_decel_unit: assert property ( // see R2
        ##1 decelRate.unit == $past(ctrlMode))
        else $error("decel unit not following mode");

    a_freq_base: assert property ( // see R6
        (st_r.config1[`CLR_FREQ_LSB +: 4] == 4'h0) |=> switchFreqKhz == 7'h0a)
        else $error("code 0 not 10 khz");

    a_freq_clamp: assert property ( // see R7
        (st_r.config1[`CLR_FREQ_LSB +: 4] > 4'hd)
        |=> (freqCodeBad && switchFreqKhz == 7'h4b))
        else $error("undefined frequency code not clamped");

    a_freq_good: assert property ( // see R6
        (st_r.config1[`CLR_FREQ_LSB +: 4] <= 4'hd) |=> !freqCodeBad)
        else $error("defined frequency code flagged");

    a_pulse_undef: assert property ( // see R10
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h3) |=> !speedPulseOutput)
        else $error("pulse under undefined selection");

    a_pulse_try_ok: assert property ( // see R10
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h2 && motorPhase == PHASE_OPEN
         && firstTry && rawSpeedPulse) |=> speedPulseOutput)
        else $error("pulse missing on first try");

    a_pulse_loop_ok: assert property ( // see R9
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h1 && motorPhase == PHASE_CLOSED
         && rawSpeedPulse) |=> speedPulseOutput)
        else $error("pulse missing in closed loop");

    a_pulse_open: assert property ( // see R8
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h0 && motorPhase == PHASE_OPEN
         && rawSpeedPulse) |=> speedPulseOutput)
        else $error("pulse missing in open loop");

    a_pulse_idle: assert property ( // see R8
        (st_r.config1[`CLR_PULSE_SEL_LSB +: 2] == 2'h0 && motorPhase == PHASE_IDLE)
        |=> !speedPulseOutput)
        else $error("pulse while idle");

endmodule : closed_loop_rate_config

// ---- rtl/rate_code_decode.sv ----
// rate code to scaled rate lookup
`timescale 1ns/100ps
module rate_code_decode
    import closed_loop_rate_pkg::*;
(
    // code in
    input wire logic [4:0] code,
    input wire ctrl_mode_e mode,
    // rate out
    output rate_s rate
);

    function automatic logic [19:0] code_to_tenths(input logic [4:0] c);
        case (c)
            5'h00: code_to_tenths = 20'h00005;
            5'h01: code_to_tenths = 20'h0000a;
            5'h02: code_to_tenths = 20'h00019;
            5'h03: code_to_tenths = 20'h00032;
            5'h04: code_to_tenths = 20'h0004b;
            5'h05: code_to_tenths = 20'h00064;
            5'h06: code_to_tenths = 20'h000c8;
            5'h07: code_to_tenths = 20'h00190;
            5'h08: code_to_tenths = 20'h00258;
            5'h09: code_to_tenths = 20'h00320;
            5'h0a: code_to_tenths = 20'h003e8;
            5'h0b: code_to_tenths = 20'h007d0;
            5'h0c: code_to_tenths = 20'h00bb8;
            5'h0d: code_to_tenths = 20'h00fa0;
            5'h0e: code_to_tenths = 20'h01388;
            5'h0f: code_to_tenths = 20'h01770;
            5'h10: code_to_tenths = 20'h01b58;
            5'h11: code_to_tenths = 20'h01f40;
            5'h12: code_to_tenths = 20'h02328;
            5'h13: code_to_tenths = 20'h02710;
            5'h14: code_to_tenths = 20'h04e20;
            5'h15: code_to_tenths = 20'h09c40;
            5'h16: code_to_tenths = 20'h0ea60;
            5'h17: code_to_tenths = 20'h13880;
            5'h18: code_to_tenths = 20'h186a0;
            5'h19: code_to_tenths = 20'h30d40;
            5'h1a: code_to_tenths = 20'h493e0;
            5'h1b: code_to_tenths = 20'h61a80;
            5'h1c: code_to_tenths = 20'h7a120;
            5'h1d: code_to_tenths = 20'h927c0;
            5'h1e: code_to_tenths = 20'haae60;
            default: code_to_tenths = 20'h00000;
        endcase
    endfunction : code_to_tenths

    always_comb begin
        rate.tenths = code_to_tenths(code); // see R1
        rate.noLimit = (code == `CLR_NO_LIMIT); // see R1
        rate.unit = mode; // see R2
    end

endmodule : rate_code_decode

// ---- testbench/closed_loop_rate_config_bench.sv ----
// self-checking bench for the closed-loop rate configuration register
`timescale 1ns/100ps
module closed_loop_rate_config_bench
    import closed_loop_rate_pkg::*;
;
    // ==========================================================
    // signals
    logic core_clk;
    logic srst;
    reg_req_s regReq;
    logic [31:0] rdata;
    ctrl_mode_e ctrlMode;
    motor_phase_e motorPhase;
    logic firstTry;
    logic rawSpeedPulse;
    rate_s accelRate;
    rate_s decelRate;
    logic [6:0] switchFreqKhz;
    logic freqCodeBad;
    logic antiVoltageSurge;
    logic speedPulseOutput;
    int n_fail;
    int checks;
    logic [31:0] rv;
    logic [4:0] codes [4] = '{5'h00, 5'h04, 5'h13, 5'h1e};
    logic [19:0] tenths [4] = '{20'd5, 20'd75, 20'd10000, 20'd700000};

    closed_loop_rate_config dut (
        .core_clk(core_clk), .srst(srst), .regReq(regReq), .rdata(rdata),
        .ctrlMode(ctrlMode), .motorPhase(motorPhase), .firstTry(firstTry),
        .rawSpeedPulse(rawSpeedPulse), .accelRate(accelRate), .decelRate(decelRate),
        .switchFreqKhz(switchFreqKhz), .freqCodeBad(freqCodeBad),
        .antiVoltageSurge(antiVoltageSurge), .speedPulseOutput(speedPulseOutput)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ==========================================================
    // access and compare tasks
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        regReq.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        regReq.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    // field packing: accel, decel source, decel, frequency, pulse select, surge
    task automatic cfg(input logic [4:0] a, input logic s, input logic [4:0] d,
                       input logic [3:0] f, input logic [1:0] p, input logic v,
                       input logic [1:0] m);
        wr(8'h88, {2'b00, a, s, d, f, 1'b0, p, 8'h00, v, 3'b000});
        @(posedge core_clk);
        ctrlMode <= ctrl_mode_e'(m);
        repeat (3) @(posedge core_clk);
        #1;
    endtask : cfg

    task automatic chkRate(input string n, input rate_s r, input logic [19:0] t,
                           input logic nl, input logic [1:0] u);
        chk({n, " limitless"}, 32'(r.noLimit), 32'(nl));
        chk({n, " unit"}, 32'(r.unit), 32'(u));
        if (!nl) chk({n, " tenths"}, 32'(r.tenths), 32'(t));
    endtask : chkRate

    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ==========================================================
    // tests
    initial begin
        n_fail = 0;
        checks = 0;
        srst = 1'b1;
        regReq = '0;
        ctrlMode = MODE_SPEED;
        motorPhase = PHASE_IDLE;
        firstTry = 1'b0;
        rawSpeedPulse = 1'b0;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        rd(8'h88, rv);
        chk("reset value", rv, 32'h0);
        wr(8'h88, 32'hffff_ffff);
        rd(8'h88, rv);
        chk("reserved bits", rv, 32'h3fff_bfff);
        wr(8'h84, 32'h0);
        rd(8'h88, rv);
        chk("unmapped write", rv, 32'h3fff_bfff);
        rd(8'h84, rv);
        chk("unmapped read", rv, 32'h0);
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 4; i++) begin
                cfg(codes[i], 1'b0, codes[3 - i], 4'h0, 2'h0, 1'b0, m[1:0]);
                chkRate("accel", accelRate, tenths[i], 1'b0, m[1:0]);
                chkRate("decel", decelRate, tenths[3 - i], 1'b0, m[1:0]);
            end
            cfg(5'h1f, 1'b0, 5'h1f, 4'h0, 2'h0, 1'b0, m[1:0]);
            chkRate("accel free", accelRate, 20'd0, 1'b1, m[1:0]);
            chkRate("decel free", decelRate, 20'd0, 1'b1, m[1:0]);
        end
        cfg(5'h04, 1'b1, 5'h1f, 4'h0, 2'h0, 1'b0, 2'd1);
        chkRate("decel from accel", decelRate, 20'd75, 1'b0, 2'd1);
        cfg(5'h04, 1'b0, 5'h1f, 4'h0, 2'h0, 1'b1, 2'd0);
        chk("surge bit", 32'(antiVoltageSurge), 32'h1);
        chkRate("surge speed", decelRate, 20'd75, 1'b0, 2'd0);
        cfg(5'h04, 1'b0, 5'h1f, 4'h0, 2'h0, 1'b1, 2'd1);
        chkRate("surge power", decelRate, 20'd0, 1'b1, 2'd1);
        for (int f = 0; f < 16; f++) begin
            cfg(5'h0, 1'b0, 5'h0, f[3:0], 2'h0, 1'b0, 2'd0);
            chk("freq", 32'(switchFreqKhz), (f <= 13) ? 32'(10 + 5 * f) : 32'd75);
            chk("freq bad", 32'(freqCodeBad), 32'(f > 13));
        end
        for (int s = 0; s < 4; s++) begin
            cfg(5'h0, 1'b0, 5'h0, 4'h0, s[1:0], 1'b0, 2'd0);
            for (int ph = 0; ph < 4; ph++) begin
                for (int ft = 0; ft < 2; ft++) begin
                    @(posedge core_clk);
                    motorPhase <= motor_phase_e'(ph[1:0]);
                    firstTry <= ft[0];
                    rawSpeedPulse <= (ph != 1) || (ft == 1);
                    repeat (2) @(posedge core_clk);
                    #1;
                    chk("speed pulse", 32'(speedPulseOutput),
                        32'(((ph != 1) || (ft == 1)) && ((s == 0 && ph != 0) ||
                        (s == 1 && ph == 3) || (s == 2 && ph == 2 && ft == 1))));
                end
            end
        end
        // phase closed, first try and raw pulse still high from the last step
        cfg(5'h0, 1'b0, 5'h0, 4'he, 2'h0, 1'b0, 2'd2);
        rd(8'h8c, rv);
        chk("status", rv, 32'h0000_00ec);
        @(posedge core_clk);
        #1;
        chk("read data idle", rdata, 32'h0);
        close_out();
    end

    // hang guard: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        close_out();
    end
endmodule : closed_loop_rate_config_bench
